// file: verilog/hrp_pkg.sv
// Package for the host read port: address map, timing and state codes
package hrp_pkg;
  localparam int unsigned CLK_MHZ          = 50;
  localparam int unsigned CYCLE_NS         = 165;
  localparam int unsigned CYCLE_CLKS       = (CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BURST_MAX        = 16;
  localparam int          ADDR_W           = 7;
  localparam int          DATA_W           = 16;
  localparam logic [15:0] DATA_RST         = 16'h0000;
  // Word offsets (address bits A[7:1]) of the read resources
  localparam logic [6:0]  OFS_RXDATA_LO    = 7'h00;
  localparam logic [6:0]  OFS_RXDATA_HI    = 7'h0f;
  localparam logic [6:0]  OFS_RXSTS        = 7'h20;
  localparam logic [6:0]  OFS_RXSTS_PEEK   = 7'h22;
  localparam logic [6:0]  OFS_TXSTS        = 7'h24;
  localparam logic [6:0]  OFS_TXSTS_PEEK   = 7'h26;
  localparam logic [6:0]  OFS_CSR_LO       = 7'h28;
  localparam logic [3:0]  BCNT_RST         = 4'h0;
  typedef enum logic [1:0] {
    HRP_IDLE  = 2'b00,
    HRP_READ  = 2'b01,
    HRP_GAP   = 2'b10
  } hrp_state_t;
endpackage

// file: verilog/hrp_read_port.sv
// Host read port: strobe decode, resource select, latched data and bus drive
`timescale 1ns/1ns
module hrp_read_port
  import hrp_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      chip_select_n,
  input  wire logic                      read_strobe_n,
  input  wire logic [hrp_pkg::ADDR_W-1:0] addr,
  input  wire logic                      queue_window_sel,
  input  wire logic [hrp_pkg::DATA_W-1:0] csr_rdata,
  input  wire logic [hrp_pkg::DATA_W-1:0] rx_data_word,
  input  wire logic [hrp_pkg::DATA_W-1:0] rx_status_word,
  input  wire logic [hrp_pkg::DATA_W-1:0] tx_status_word,
  output logic     [hrp_pkg::ADDR_W-1:0] csr_addr,
  output logic                           csr_latch,
  output logic                           rx_data_pop,
  output logic                           rx_status_pop,
  output logic                           tx_status_pop,
  output logic     [hrp_pkg::DATA_W-1:0] data_out,
  output logic                           data_oe,
  output logic                           burst_overrun
);
  import hrp_pkg::*;

  hrp_state_t             state_r, state_nxt;
  logic [DATA_W-1:0]      data_r;
  logic [ADDR_W-1:0]      addr_r;
  logic                   win_r;
  logic [3:0]             bcnt_r;
  logic                   ovr_r;

  // Cycle is active only while both strobes are low
  wire active     = !chip_select_n && !read_strobe_n;
  wire rd_start   = active && (state_r != HRP_READ);
  wire addr_chg   = active && (state_r == HRP_READ) && (addr != addr_r);
  wire rd_end     = !active && (state_r == HRP_READ);
  wire take       = rd_start || addr_chg;
  // Window select overrides the upper decode; only A[2:1] survive
  wire win_now    = queue_window_sel;
  wire [ADDR_W-1:0] eff_addr = win_now ? {5'h00, addr[1:0]} : addr;
  wire sel_rxd    = win_now || (eff_addr <= OFS_RXDATA_HI);
  wire sel_rxs    = !win_now && (eff_addr == OFS_RXSTS);
  wire sel_rxsp   = !win_now && (eff_addr == OFS_RXSTS_PEEK);
  wire sel_txs    = !win_now && (eff_addr == OFS_TXSTS);
  wire sel_txsp   = !win_now && (eff_addr == OFS_TXSTS_PEEK);
  wire [DATA_W-1:0] sel_word =
    sel_rxd               ? rx_data_word   :
    (sel_rxs || sel_rxsp) ? rx_status_word :
    (sel_txs || sel_txsp) ? tx_status_word : csr_rdata;
  // Register bursts beyond the documented length are flagged, not blocked
  wire reg_burst  = !win_r && !sel_rxd;
  wire ovr_nxt    = addr_chg && reg_burst && (bcnt_r == 4'(BURST_MAX - 1));

  // Next state: idle, reading, or released gap
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HRP_IDLE: if (active) state_nxt = HRP_READ;
      HRP_READ: if (!active) state_nxt = HRP_GAP;
      HRP_GAP:  state_nxt = active ? HRP_READ : HRP_IDLE;
      default:  state_nxt = HRP_IDLE;
    endcase
  end

  // Pops fire once per taken read; counter latch only at the start of a non-queue cycle
  assign rx_data_pop   = take && sel_rxd;
  assign rx_status_pop = take && sel_rxs;
  assign tx_status_pop = take && sel_txs;
  assign csr_latch     = rd_start && !sel_rxd;
  assign csr_addr      = eff_addr;
  assign burst_overrun = ovr_r;
  assign data_out      = data_r;
  // Bus is only driven while the cycle is live
  assign data_oe       = active && (state_r == HRP_READ);

  // Data is held from the capture edge so counters stay stable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= HRP_IDLE;
      data_r  <= DATA_RST;
      addr_r  <= '0;
      win_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        data_r <= sel_word;
        addr_r <= addr;
        win_r  <= win_now;
      end
    end
  end

  // Halfword count within one register burst
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_r <= BCNT_RST;
      ovr_r  <= 1'b0;
    end else begin
      if (rd_start) bcnt_r <= BCNT_RST;
      else if (addr_chg && bcnt_r != 4'(BURST_MAX - 1)) bcnt_r <= bcnt_r + 4'h1;
      if (rd_end) ovr_r <= 1'b0;
      else if (ovr_nxt) ovr_r <= 1'b1;
    end
  end

  // Output enable never rises outside an active cycle
  drive_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    data_oe |-> active)
    else $error("data driven outside read");

  // Release drops the output enable at once
  release_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_end |-> !data_oe)
    else $error("data still driven");

  // A start captures the selected word one edge later
  start_cap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    take |=> data_r == $past(sel_word))
    else $error("read data not captured");

  // Data stays stable while the address holds
  data_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_r == HRP_READ && active && !take) |=> $stable(data_r))
    else $error("data moved mid cycle");

  // Window select makes every taken read pop the rx data queue and no other resource
  window_pop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (take && queue_window_sel) |-> rx_data_pop && !rx_status_pop && !tx_status_pop)
    else $error("window read missed queue");

  // Upper address bits do not matter in window mode
  low_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    queue_window_sel |-> csr_addr[6:2] == 5'h00)
    else $error("upper bits decoded");

  // Receive status pops only on its own offset
  sts_pop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_status_pop |-> take && addr == OFS_RXSTS && !queue_window_sel)
    else $error("stray status pop");

  // One pop per start, never repeated on a held cycle
  single_pop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rx_data_pop && !addr_chg) |=> (!rx_data_pop || $past(addr) != addr || !active)
      or (state_r == HRP_READ && take))
    else $error("queue popped twice");

  // Counter latch only opens a live cycle
  latch_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    csr_latch |-> active && state_r != HRP_READ)
    else $error("latch mid cycle");

  // Seventeenth register halfword raises the overrun flag
  burst_cap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ovr_nxt |=> burst_overrun)
    else $error("burst overrun not flagged");

  // Transmit status pops only on its own offset
  tx_pop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tx_status_pop |-> take && addr == OFS_TXSTS && !queue_window_sel)
    else $error("stray tx status pop");

  // Receive status never pops together with another resource
  one_pop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_status_pop |-> !tx_status_pop && !rx_data_pop)
    else $error("two resources popped");

  // A live cycle keeps the bus driven
  oe_live_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_r == HRP_READ && active) |-> data_oe)
    else $error("bus not driven in cycle");

  // Both strobes low opens the cycle on the next edge
  open_cyc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_start |=> state_r == HRP_READ)
    else $error("cycle did not open");

  // Either strobe high closes the cycle
  close_cyc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_end |=> state_r == HRP_GAP)
    else $error("cycle did not close");

  // Overrun flag never outlives its burst
  ovr_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_end |=> !burst_overrun)
    else $error("overrun not cleared");

  // Each new burst counts from zero
  cnt_open_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_start |=> bcnt_r == BCNT_RST)
    else $error("burst count not reset");

  // Every window address step pops the next queue halfword
  win_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (addr_chg && queue_window_sel) |-> rx_data_pop)
    else $error("queue step not popped");

  // Queue reads never freeze the counters
  latch_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    csr_latch |-> !rx_data_pop)
    else $error("latch on queue read");
endmodule

// file: tb/hrp_partner.sv
// Far-side model: register values and queue head words
`timescale 1ns/1ns
module hrp_partner
  import hrp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [6:0]  csr_addr,
  input  wire logic        rx_data_pop,
  input  wire logic        rx_status_pop,
  input  wire logic        tx_status_pop,
  output logic      [15:0] csr_rdata,
  output logic      [15:0] rx_data_word,
  output logic      [15:0] rx_status_word,
  output logic      [15:0] tx_status_word
);
  logic [11:0] rxd_r, rxs_r, txs_r;
  // Register value tracks its address, so a wrong decode shows
  assign csr_rdata      = {9'h180, csr_addr};
  assign rx_data_word   = {4'h1, rxd_r};
  assign rx_status_word = {4'h2, rxs_r};
  assign tx_status_word = {4'h3, txs_r};
  // Each head advances once per pop; a double pop skips a word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_r <= 12'h000;
      rxs_r <= 12'h000;
      txs_r <= 12'h000;
    end else begin
      rxd_r <= rxd_r + 12'(rx_data_pop);
      rxs_r <= rxs_r + 12'(rx_status_pop);
      txs_r <= txs_r + 12'(tx_status_pop);
    end
  end
endmodule

// file: tb/testbench.sv
// Testbench for the host read port
`timescale 1ns/1ns
module testbench;
  import hrp_pkg::*;
  logic        core_clk, rst_n, chip_select_n, read_strobe_n, queue_window_sel;
  logic        csr_latch, rx_data_pop, rx_status_pop, tx_status_pop, data_oe, burst_overrun;
  logic [6:0]  addr, csr_addr;
  logic [15:0] csr_rdata, rx_data_word, rx_status_word, tx_status_word, data_out;
  int          n_mismatch, compares, cycles, n_latch;
  hrp_read_port i_dut (.core_clk, .rst_n, .chip_select_n, .read_strobe_n, .addr,
    .queue_window_sel, .csr_rdata, .rx_data_word, .rx_status_word, .tx_status_word,
    .csr_addr, .csr_latch, .rx_data_pop, .rx_status_pop, .tx_status_pop, .data_out,
    .data_oe, .burst_overrun);
  hrp_partner i_far (.core_clk, .rst_n, .csr_addr, .rx_data_pop, .rx_status_pop,
    .tx_status_pop, .csr_rdata, .rx_data_word, .rx_status_word, .tx_status_word);
  task automatic summarize();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rd_open(input logic sel);
    queue_window_sel = sel;
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
  endtask
  // Close by one strobe, bus must float by the next edge; then a gap over 13 ns
  task automatic rd_close(input logic by_cs);
    if (by_cs) chip_select_n = 1'b1;
    else read_strobe_n = 1'b1;
    step(1);
    chk1(data_oe, 1'b0);
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    step(1);
  endtask
  // One address phase of the full cycle time
  task automatic hold(input logic [6:0] a, input logic [15:0] exp);
    addr = a;
    step(CYCLE_CLKS);
    chk(data_out, exp);
    chk1(data_oe, 1'b1);
  endtask
  // Counter latch pulses, counted at the edge that takes them
  always @(posedge core_clk) if (csr_latch === 1'b1) n_latch++;
  task automatic single(input logic [6:0] a, input logic s, input logic [15:0] e, input logic c);
    int l0;
    l0 = n_latch;
    rd_open(s);
    hold(a, e);
    rd_close(c);
    chk(16'(n_latch - l0), {15'h0, !s && (a > 7'h0f)});
  endtask
  task automatic t_single();
    single(7'h28, 1'b0, 16'hc028, 1'b1);
    single(7'h7f, 1'b0, 16'hc07f, 1'b0);
    single(7'h03, 1'b0, 16'h1000, 1'b1);
    single(7'h7b, 1'b1, 16'h1001, 1'b0);
    single(7'h22, 1'b0, 16'h2000, 1'b1);
    single(7'h20, 1'b0, 16'h2000, 1'b1);
    single(7'h20, 1'b0, 16'h2001, 1'b0);
    single(7'h24, 1'b0, 16'h3000, 1'b1);
    single(7'h26, 1'b0, 16'h3001, 1'b0);
    single(7'h30, 1'b0, 16'hc030, 1'b1);
    single(7'h32, 1'b0, 16'hc032, 1'b0);
    single(7'h32, 1'b0, 16'hc032, 1'b1);
    single(7'h30, 1'b0, 16'hc030, 1'b0);
    single(7'h34, 1'b0, 16'hc034, 1'b1);
    single(7'h32, 1'b0, 16'hc032, 1'b0);
    single(7'h32, 1'b0, 16'hc032, 1'b1);
    single(7'h34, 1'b0, 16'hc034, 1'b0);
    $display("single reads done");
  endtask
  task automatic t_burst();
    int l0;
    l0 = n_latch;
    rd_open(1'b0);
    for (int i = 0; i < 17; i++) begin
      hold(7'h28 + 7'(i), 16'hc028 + 16'(i));
      chk1(burst_overrun, i == 16);
    end
    rd_close(1'b1);
    chk1(burst_overrun, 1'b0);
    chk(16'(n_latch - l0), 16'h0001);
    $display("register burst done");
  endtask
  task automatic t_qburst();
    int l0;
    l0 = n_latch;
    rd_open(1'b1);
    for (int i = 0; i < 20; i++) begin
      hold(7'(i * 9), 16'h1002 + 16'(i));
      chk1(burst_overrun, 1'b0);
    end
    rd_close(1'b0);
    chk(16'(n_latch - l0), 16'h0000);
    $display("queue burst done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Hang guard: far beyond the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'b0;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    addr = 7'h00;
    queue_window_sel = 1'b0;
    step(8);
    rst_n = 1'b1;
    chk1(data_oe, 1'b0);
    t_single();
    t_burst();
    t_qburst();
    summarize();
  end
endmodule
